/* File: core/scg_wdt.sv */
module scg_wdt
	import scg_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_load,
	input wire logic i_tick,
	output logic [WDT_W-1:0] o_count
);
	logic [WDT_W-1:0] count_reg;
	logic [WDT_W-1:0] count_next;

	// load wins over a tick in the same cycle
	always_comb begin
		count_next = count_reg;
		if (i_load) begin
			count_next = WDT_PRELOAD;
		end else if (i_tick) begin
			count_next = count_reg - WDT_ONE;
		end
	end

	// counter register
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			count_reg <= WDT_PRELOAD;
		end else begin
			count_reg <= count_next;
		end
	end

	assign o_count = count_reg;
endmodule // scg_wdt

/* File: core/scg_top.sv */
package scg_pkg;
	localparam int WDT_W = 12;
	localparam int WDT_MSB = 11;
	localparam logic [11:0] WDT_PRELOAD = 12'hfff;
	localparam logic [11:0] WDT_ONE = 12'h001;
	localparam int PRE_W = 9;
	localparam logic [8:0] PRE_ONE = 9'h001;
	localparam logic [8:0] PRE_RESET = 9'h000;
	// prescaler patterns that mark the last cycle of each divided period
	localparam logic [8:0] DIV16_MASK = 9'h00f;
	localparam logic [8:0] DIV32_MASK = 9'h01f;
	localparam logic [8:0] DIV512_MASK = 9'h1ff;
	typedef enum logic [1:0] {
		ST_RUN,
		ST_STOP,
		ST_SETTLE,
		ST_WAIT
	} scg_state_e;
endpackage : scg_pkg

module scg_top
	import scg_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_stop_instruction,
	input wire logic i_wait_instruction,
	input wire logic i_irq,
	input wire logic i_wdt_freq_sel,
	input wire logic i_wdt_restart,
	output logic o_cpu_clk_run,
	output logic o_osc_run,
	output logic o_wdt_forced,
	output logic o_low_power,
	output logic [WDT_W-1:0] o_wdt_count
);
	scg_state_e state_reg;
	scg_state_e state_next;
	logic cpu_run_reg;
	logic cpu_run_next;
	logic osc_run_reg;
	logic osc_run_next;
	logic forced_reg;
	logic forced_next;
	logic lp_reg;
	logic lp_next;
	logic [PRE_W-1:0] pre_reg;
	logic [PRE_W-1:0] pre_next;
	logic div32_clock;
	logic div16_tick;
	logic div512_tick;
	logic wdt_tick;
	logic wdt_load;
	logic wdt_msb;
	logic [WDT_W-1:0] wdt_count;

	// prescaler only advances while the oscillator runs
	always_comb begin
		pre_next = pre_reg;
		if (osc_run_reg) begin
			pre_next = pre_reg + PRE_ONE;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pre_reg <= PRE_RESET;
		end else begin
			pre_reg <= pre_next;
		end
	end

	// divided-clock enables and watchdog input selection
	always_comb begin
		div32_clock = osc_run_reg && ((pre_reg & DIV32_MASK) == DIV32_MASK);
		div16_tick = osc_run_reg && ((pre_reg & DIV16_MASK) == DIV16_MASK);
		div512_tick = osc_run_reg && (pre_reg == DIV512_MASK);
		if (forced_reg) begin
			wdt_tick = div32_clock;
		end else if (i_wdt_freq_sel) begin
			wdt_tick = div16_tick;
		end else begin
			wdt_tick = div512_tick;
		end
	end

	assign wdt_msb = wdt_count[WDT_MSB];

	// mode sequencing and clock gating
	always_comb begin
		state_next = state_reg;
		cpu_run_next = cpu_run_reg;
		osc_run_next = osc_run_reg;
		forced_next = forced_reg;
		wdt_load = i_wdt_restart;
		if (forced_reg && !wdt_msb) begin
			forced_next = 1'b0;
		end
		case (state_reg)
			ST_RUN: begin
				if (i_stop_instruction) begin
					state_next = ST_STOP;
					cpu_run_next = 1'b0;
					osc_run_next = 1'b0;
					wdt_load = 1'b1;
					forced_next = 1'b1;
				end else if (i_wait_instruction) begin
					state_next = ST_WAIT;
					cpu_run_next = 1'b0;
				end
			end
			ST_STOP: begin
				// without an enabled interrupt only reset leaves here
				if (i_irq) begin
					state_next = ST_SETTLE;
					osc_run_next = 1'b1;
				end
			end
			ST_SETTLE: begin
				if (!wdt_msb) begin
					state_next = ST_RUN;
					cpu_run_next = 1'b1;
				end
			end
			ST_WAIT: begin
				if (i_irq) begin
					state_next = ST_RUN;
					cpu_run_next = 1'b1;
				end
			end
			default: begin
				state_next = ST_RUN;
			end
		endcase
		lp_next = (state_next != ST_RUN);
	end

	// reset always returns to full run
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_reg <= ST_RUN;
			cpu_run_reg <= 1'b1;
			osc_run_reg <= 1'b1;
			forced_reg <= 1'b0;
			lp_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cpu_run_reg <= cpu_run_next;
			osc_run_reg <= osc_run_next;
			forced_reg <= forced_next;
			lp_reg <= lp_next;
		end
	end

	// watchdog counter
	scg_wdt u_wdt (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_load(wdt_load),
		.i_tick(wdt_tick),
		.o_count(wdt_count)
	);

	assign o_cpu_clk_run = cpu_run_reg;
	assign o_osc_run = osc_run_reg;
	assign o_wdt_forced = forced_reg;
	assign o_low_power = lp_reg;
	assign o_wdt_count = wdt_count;

	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	a_stop_gates_clk: assert property (
		state_reg == ST_RUN && i_stop_instruction |=>
		!cpu_run_reg && !osc_run_reg && state_reg == ST_STOP)
		else $error("stop did not gate cpu clock and oscillator");
	a_stop_preload: assert property (
		state_reg == ST_RUN && i_stop_instruction |=>
		wdt_count == WDT_PRELOAD && forced_reg)
		else $error("stop did not preload and force watchdog");
	a_force_release: assert property (
		forced_reg && !wdt_msb |=> !forced_reg)
		else $error("forced input not released after msb clear");
	a_stop_irq_osc: assert property (
		state_reg == ST_STOP && i_irq |=> osc_run_reg && !cpu_run_reg)
		else $error("interrupt in stop did not restart oscillator");
	a_settle_hold: assert property (
		state_reg == ST_SETTLE && wdt_msb |-> !cpu_run_reg)
		else $error("cpu clock ran before msb cleared");
	a_wait_osc_on: assert property (
		state_reg == ST_WAIT |-> osc_run_reg && !cpu_run_reg)
		else $error("wait state clock gating wrong");
	a_wait_wake: assert property (
		state_reg == ST_WAIT && i_irq |=> cpu_run_reg && state_reg == ST_RUN)
		else $error("wait did not wake at once");
	a_stop_hold: assert property (
		state_reg == ST_STOP && !i_irq |=> state_reg == ST_STOP)
		else $error("stop left without interrupt");
	a_settle_count: assert property (
		state_reg == ST_SETTLE && div32_clock && !i_wdt_restart |=>
		wdt_count == $past(wdt_count) - WDT_ONE)
		else $error("watchdog did not count during settling");
	a_settle_exit: assert property (
		state_reg == ST_SETTLE && !wdt_msb |=> cpu_run_reg)
		else $error("settling did not end on msb clear");
	a_stop_osc_off: assert property (
		state_reg == ST_STOP |-> !osc_run_reg && !cpu_run_reg)
		else $error("stop state left a clock running");
	a_stop_wdt_frozen: assert property (
		state_reg == ST_STOP && !i_wdt_restart |=> $stable(wdt_count))
		else $error("watchdog counted with oscillator stopped");

	c_stop_entry: cover property (state_reg == ST_RUN && i_stop_instruction);
	c_settle_done: cover property (state_reg == ST_SETTLE && !wdt_msb);
	c_wait_wake: cover property (state_reg == ST_WAIT && i_irq);
	c_stop_wake: cover property (state_reg == ST_STOP && i_irq);
endmodule // scg_top

/* File: verif/scg_irq_model.sv */
// interrupt source beside the cpu: answers a low-power state after a delay
module scg_irq_model #(
	parameter int DELAY = 3
) (
	input wire logic i_clk,
	input wire logic i_enable,
	input wire logic i_low_power,
	output logic o_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	// no interrupt is raised unless software enabled it first
	always @(negedge i_clk) begin
		if (!i_enable || !i_low_power) begin
			cnt = 0;
			o_irq <= 1'b0;
		end else if (cnt == DELAY) begin
			o_irq <= 1'b1;
		end else begin
			cnt++;
		end
	end
endmodule // scg_irq_model

/* File: verif/stop_wait_clock_gating_tb.sv */
module stop_wait_clock_gating_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import scg_pkg::*;
	logic clk = 0, rstn = 0, stop_instruction = 0, wt = 0, en = 0, irq;
	logic cpu, osc, frc, lp;
	logic sel = 1; // watchdog frequency flag, 1 = div16
	logic [WDT_W-1:0] cnt;
	int bad_count = 0, cmp_count = 0;
	// rows: stop, wait, then cpu, osc, forced, low power
	logic [5:0] rows [4] = '{6'h0c, 6'h15, 6'h23, 6'h33};
	// clock of 8 ns
	always #4 clk = ~clk;
	scg_top dut_u (.i_clk(clk), .i_rstn(rstn), .i_stop_instruction(stop_instruction),
		.i_wait_instruction(wt), .i_irq(irq), .i_wdt_freq_sel(sel),
		.i_wdt_restart(1'b0), .o_cpu_clk_run(cpu), .o_osc_run(osc),
		.o_wdt_forced(frc), .o_low_power(lp), .o_wdt_count(cnt));
	scg_irq_model #(.DELAY(3)) irq_u (.i_clk(clk), .i_enable(en),
		.i_low_power(lp), .o_irq(irq));
	// compare and count
	task check(input logic [11:0] seen, input logic [11:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task stop_test;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// reset held two cycles
	task do_reset;
		rstn = 0;
		repeat (2) @(negedge clk);
		rstn = 1;
	endtask
	// one-cycle instruction pulse, outputs settled one edge later
	task pulse(input logic s, input logic w);
		@(negedge clk);
		stop_instruction = s;
		wt = w;
		@(negedge clk);
		stop_instruction = 0;
		wt = 0;
		@(negedge clk);
	endtask
	// bounded wait for a level; which: 0 low power, 1 oscillator, 2 cpu
	task automatic await(input int which, input logic v, input int n);
		logic sig;
		sig = (which == 0) ? lp : ((which == 1) ? osc : cpu);
		while (sig !== v && n > 0) begin
			@(negedge clk);
			n--;
			sig = (which == 0) ? lp : ((which == 1) ? osc : cpu);
		end
	endtask
	// main sequence: table rows, then wake-ups through interrupts
	initial begin
		do_reset;
		foreach (rows[i]) begin
			check({8'h00, cpu, osc, frc, lp}, 12'h00c);
			check(cnt, 12'hfff);
			pulse(rows[i][5], rows[i][4]);
			check({8'h00, cpu, osc, frc, lp}, {8'h00, rows[i][3:0]});
			do_reset;
		end
		en = 1;
		pulse(1'b0, 1'b1);
		check({10'h000, osc, lp}, 12'h003);
		await(0, 1'b0, 20);
		check({10'h000, cpu, lp}, 12'h002);
		pulse(1'b1, 1'b0);
		check({cnt[10:0], frc}, 12'hfff);
		await(1, 1'b1, 50);
		check({11'h000, cpu}, 12'h000);
		await(2, 1'b1, 70000);
		check(cnt, 12'h7ff);
		check({11'h000, frc}, 12'h000);
		// released input follows the flag: two div16 ticks in 32 cycles
		repeat (32) @(negedge clk);
		check(cnt, 12'h7fd);
		// from reset the prescaler starts at zero: flag 0 gives no tick
		do_reset;
		sel = 0;
		repeat (16) @(negedge clk);
		check(cnt, 12'hfff);
		sel = 1;
		repeat (16) @(negedge clk);
		check(cnt, 12'hffe);
		stop_test;
	end
	// hang guard
	initial begin
		repeat (80000) @(posedge clk);
		bad_count++;
		stop_test;
	end
endmodule // stop_wait_clock_gating_tb
